// File: buck_ctrl_defs.svh
// constants for the dual step-down converter control block
`ifndef BUCK_CTRL_DEFS_SVH
`define BUCK_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and time
// ----------------------------------------------------------------------------
`define REF_CLK_MHZ      32'h0000_000A
`define NS_PER_US        32'h0000_03E8
// ramp step period per slew code, in ns: 8000, 4000, 2000, 1000, 500
`define STEP_T0_NS       32'h0000_1F40
`define STEP_T1_NS       32'h0000_0FA0
`define STEP_T2_NS       32'h0000_07D0
`define STEP_T3_NS       32'h0000_03E8
`define STEP_T4_NS       32'h0000_01F4
`define STEP_CYC(t)      (((t) * `REF_CLK_MHZ) / `NS_PER_US)

// ----------------------------------------------------------------------------
// levels and reset values (one level code is a 10 mV step)
// ----------------------------------------------------------------------------
`define LEVEL_ZERO       8'h00
`define LEVEL_STEP       8'h01
`define PRESET_RST       8'h46
`define SHDN_IMMEDIATE   3'h0

// ----------------------------------------------------------------------------
// oscillator trim: 8 MHz core in 160 kHz steps, switching at half
// ----------------------------------------------------------------------------
`define OSC_NOM_KHZ      16'h1F40
`define OSC_STEP_KHZ     16'h00A0
`define SW_NOM_KHZ       16'h0FA0
`define SW_STEP_KHZ      16'h0050

// ----------------------------------------------------------------------------
// event bit positions
// ----------------------------------------------------------------------------
`define EV_OC1           0
`define EV_OC2           1
`define EV_WARN          2
`define EV_CRIT          3

`endif

// File: buck_ctrl_pkg.sv
// types shared by the dual step-down converter control block
package buck_ctrl_pkg;

   typedef enum logic [3:0] {
      ST_OFF   = 4'b0001,
      ST_START = 4'b0010,
      ST_ON    = 4'b0100,
      ST_SHDN  = 4'b1000
   } chan_state_t;

   typedef enum logic [1:0] {
      MODE_AUTO = 2'h0,
      MODE_PWM  = 2'h1,
      MODE_PFM  = 2'h2
   } conv_mode_t;

   typedef struct packed {
      logic       ch;
      logic       sel;
      logic [7:0] level;
   } preset_write_t;

   typedef struct packed {
      logic crit;
      logic warn;
      logic oc2;
      logic oc1;
   } event_flags_t;

endpackage

// File: dual_buck_voltage_control.sv
// control logic for two step-down converter channels
//
// Summary of operation
// R1 - two preset levels per channel
// R2 - preset chosen by pin or software
// R3 - good flag follows rise/fall/high thresholds
// R4 - good flag readable and routable to pins
// R5 - preset rewrite or selector change starts ramp
// R6 - forced pulse-width mode while ramping
// R7 - 10 mV step every 8..0.5 us
// R8 - pull-down on unless disable bit set
// R9 - trim moves oscillator 160 kHz steps
// R10 - conversion mode chosen per preset
// R11 - automatic mode follows load current
// R12 - first preset after enable unless pin
// R13 - regulated target never exceeds channel ceiling
// R14 - start-up ramps at programmable rate
// R15 - ramped or immediate shutdown per channel
// R16 - over-current records event, maskable interrupt
// R17 - mask over-current events during ramps
// R18 - host sets current limit 40 percent high; no limit setting here, current_limit_i is only a trip input
// R19 - warning and critical thermal status levels
// R20 - critical thermal shuts both channels
// R21 - separate thermal events and masks
// R22 - host keeps serial clock at 20 kHz; the bench clocks the host link at 15.625 MHz (64 ns period)
// R23 - sticky events, masks gate interrupt only
// R24 - ramp moves one step, then holds
// R25 - chip enable low resets everything
`timescale 1ns/100ps
`include "buck_ctrl_defs.svh"

module dual_buck_voltage_control
   import buck_ctrl_pkg::*;
#(
   parameter int GPIO_N = 3
)(
   input  wire logic                    ref_clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    host_clk_i,
   input  wire logic                    host_wr_i,
   input  wire preset_write_t           host_wr_data_i,
   input  wire logic                    host_clr_i,
   input  wire event_flags_t            host_clr_bits_i,
   output      logic [7:0]              status_link_o,
   input  wire logic [1:0]              ch_enable_i,
   input  wire logic [1:0]              preset_selector_i,
   input  wire logic [1:0]              sel_from_pin_i,
   input  wire logic                    select_pin_i,
   input  wire logic [1:0][7:0]         output_level_ceiling_i,
   input  wire logic [2:0]              ch1_transition_slew_i,
   input  wire logic [2:0]              ch2_transition_slew_i,
   input  wire logic [1:0][2:0]         startup_ramp_rate_i,
   input  wire logic [1:0][2:0]         shutdown_ramp_rate_i,
   input  wire conv_mode_t [1:0]        ch1_conversion_mode_i,
   input  wire conv_mode_t [1:0]        ch2_conversion_mode_i,
   input  wire logic [1:0]              pulldown_disable_i,
   input  wire logic [3:0]              oscillator_trim_i,
   input  wire logic [1:0]              overcurrent_irq_mask_i,
   input  wire logic                    overcurrent_during_ramp_mask_i,
   input  wire logic                    thermal_warning_event_mask_i,
   input  wire logic                    thermal_critical_event_mask_i,
   input  wire logic                    thermal_warning_level_mask_i,
   input  wire logic [GPIO_N-1:0][1:0]  gpio_mode_i,
   input  wire logic [1:0]              load_light_i,
   input  wire logic [1:0]              above_rise_i,
   input  wire logic [1:0]              below_fall_i,
   input  wire logic [1:0]              above_high_i,
   input  wire logic [1:0]              current_limit_i,
   input  wire logic                    temp_warn_i,
   input  wire logic                    thermal_critical_status_i,
   output      logic [1:0][7:0]         target_level_o,
   output      logic [1:0]              channel_on_o,
   output      logic [1:0]              ramp_active_o,
   output      logic [1:0]              forced_pwm_o,
   output      logic [1:0]              pfm_active_o,
   output      logic [1:0]              pulldown_on_o,
   output      logic                    rail1_good_flag_o,
   output      logic                    rail2_good_flag_o,
   output      logic                    thermal_warning_status_o,
   output      logic                    thermal_critical_status_o,
   output      event_flags_t            event_flags_o,
   output      logic                    irq_n_o,
   output      logic [GPIO_N-1:0]       gpio_o,
   output      logic [GPIO_N-1:0]       gpio_oe_o,
   output      logic [15:0]             osc_freq_khz_o,
   output      logic [15:0]             sw_freq_khz_o
);

   // -------------------------------------------------------------------------
   // link side: hold write data and flip a toggle per request
   // -------------------------------------------------------------------------
   preset_write_t wr_hold;
   logic [3:0]    clr_hold;
   logic          wr_tgl;
   logic          clr_tgl;
   logic [7:0]    stat_meta;
   logic [7:0]    stat_sync;

   always_ff @(posedge host_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         wr_hold  <= '0;
         clr_hold <= '0;
         wr_tgl   <= 1'b0;
         clr_tgl  <= 1'b0;
      end else begin
         if (host_wr_i) begin
            wr_hold <= host_wr_data_i;
            wr_tgl  <= ~wr_tgl;
         end
         if (host_clr_i) begin
            clr_hold <= host_clr_bits_i;
            clr_tgl  <= ~clr_tgl;
         end
      end
   end

   // status readback: slow levels, two flops into the link clock
   always_ff @(posedge host_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         stat_meta <= '0;
         stat_sync <= '0;
      end else begin
         stat_meta <= {rail2_good_flag_o, rail1_good_flag_o, thermal_critical_status_o,
                       thermal_warning_status_o, event_flags_o};   // [R4]
         stat_sync <= stat_meta;
      end
   end
   assign status_link_o = stat_sync;

   // -------------------------------------------------------------------------
   // crossing into the reference clock; held data is stable by then
   // -------------------------------------------------------------------------
   logic [2:0] wr_sync;
   logic [2:0] clr_sync;

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         wr_sync  <= '0;
         clr_sync <= '0;
      end else begin
         wr_sync  <= {wr_sync[1:0], wr_tgl};
         clr_sync <= {clr_sync[1:0], clr_tgl};
      end
   end

   wire wr_pulse  = wr_sync[2] ^ wr_sync[1];
   wire clr_pulse = clr_sync[2] ^ clr_sync[1];

   // -------------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------------
   localparam int PIN_N = 13;
   logic [PIN_N-1:0] pin_meta;
   logic [PIN_N-1:0] pin_sync;
   logic [3:0]       edge_d;

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
         edge_d   <= '0;
      end else begin
         pin_meta <= {select_pin_i, load_light_i, above_rise_i, below_fall_i, above_high_i,
                      current_limit_i, temp_warn_i, thermal_critical_status_i};
         pin_sync <= pin_meta;
         edge_d   <= pin_sync[3:0];
      end
   end

   wire       crit_s  = pin_sync[0];
   wire       warn_s  = pin_sync[1];
   wire [1:0] ilim_s  = pin_sync[3:2];
   wire [1:0] high_s  = pin_sync[5:4];
   wire [1:0] fall_s  = pin_sync[7:6];
   wire [1:0] rise_s  = pin_sync[9:8];
   wire [1:0] light_s = pin_sync[11:10];
   wire       selp_s  = pin_sync[12];
   wire [3:0] rise_edge = pin_sync[3:0] & ~edge_d;

   // -------------------------------------------------------------------------
   // presets and step period lookup
   // -------------------------------------------------------------------------
   logic [7:0] preset [2][2];   // [R1]

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         for (int c = 0; c < 2; c++) begin
            preset[c][0] <= `PRESET_RST;
            preset[c][1] <= `PRESET_RST;
         end
      end else if (wr_pulse) begin
         preset[wr_hold.ch][wr_hold.sel] <= wr_hold.level;
      end
   end

   // codes above the fastest step saturate there
   function automatic logic [7:0] step_cycles(input logic [2:0] code);
      logic [7:0] cyc;
      cyc = 8'(`STEP_CYC(`STEP_T4_NS));
      case (code)
         3'h0:    cyc = 8'(`STEP_CYC(`STEP_T0_NS));
         3'h1:    cyc = 8'(`STEP_CYC(`STEP_T1_NS));
         3'h2:    cyc = 8'(`STEP_CYC(`STEP_T2_NS));
         3'h3:    cyc = 8'(`STEP_CYC(`STEP_T3_NS));
         default: cyc = 8'(`STEP_CYC(`STEP_T4_NS));
      endcase
      return cyc;
   endfunction

   // -------------------------------------------------------------------------
   // per-channel sequencer and ramp
   // -------------------------------------------------------------------------
   chan_state_t state [2];
   logic [7:0]  level [2];
   logic [7:0]  step_cnt [2];
   logic [1:0]  ramp_busy;
   logic [1:0]  ch_live;
   logic [1:0]  pfm_now;
   logic [7:0]  desired [2];
   logic [1:0]  good;

   for (genvar c = 0; c < 2; c++) begin : g_ch
      wire        in_start  = (state[c] == ST_START);
      // unless the pin selects, a fresh enable regulates to the first preset until the start-up ends
      wire        sel_eff   = sel_from_pin_i[c] ? selp_s :
                              (in_start ? 1'b0 : preset_selector_i[c]);   // [R2] [R12]
      wire [7:0]  pick      = preset[c][sel_eff];
      wire [7:0]  ceil      = output_level_ceiling_i[c];
      assign desired[c]     = (pick > ceil) ? ceil : pick;   // [R13]
      wire [2:0]  slew      = (c == 0) ? ch1_transition_slew_i : ch2_transition_slew_i;
      wire [2:0]  shdn_code = shutdown_ramp_rate_i[c] - 3'h1;
      wire [2:0]  code      = in_start ? startup_ramp_rate_i[c] :
                              (state[c] == ST_SHDN) ? shdn_code : slew;   // [R7] [R14]
      wire [7:0]  period    = step_cycles(code);
      wire        tick      = (step_cnt[c] >= period - 8'h01);
      wire        immediate = (shutdown_ramp_rate_i[c] == `SHDN_IMMEDIATE);
      assign ramp_busy[c]   = (state[c] == ST_ON) && (level[c] != desired[c]);   // [R5]
      assign ch_live[c]     = in_start || (state[c] == ST_ON);
      conv_mode_t mode;
      assign mode = (c == 0) ? ch1_conversion_mode_i[sel_eff] :
                               ch2_conversion_mode_i[sel_eff];   // [R10]
      assign pfm_now[c] = ch_live[c] && !ramp_busy[c] && !in_start &&
                          ((mode == MODE_PFM) || ((mode == MODE_AUTO) && light_s[c]));   // [R11]

      chan_state_t next_state;
      logic [7:0]  next_level;
      logic        moving;

      always_comb
      begin
         next_state = state[c];
         next_level = level[c];
         moving     = 1'b0;
         unique case (state[c])
            ST_OFF:
            begin
               next_level = `LEVEL_ZERO;
               if (ch_enable_i[c])
                  next_state = ST_START;
            end
            ST_START:
            begin
               moving = 1'b1;
               if (!ch_enable_i[c])
                  next_state = immediate ? ST_OFF : ST_SHDN;
               else if (level[c] >= desired[c])
                  next_state = ST_ON;
               else if (tick)
                  next_level = level[c] + `LEVEL_STEP;   // [R14]
            end
            ST_ON:
            begin
               moving = ramp_busy[c];
               if (!ch_enable_i[c])
                  next_state = immediate ? ST_OFF : ST_SHDN;   // [R15]
               else if (tick && level[c] < desired[c])
                  next_level = level[c] + `LEVEL_STEP;   // [R24]
               else if (tick && level[c] > desired[c])
                  next_level = level[c] - `LEVEL_STEP;   // [R24]
            end
            ST_SHDN:
            begin
               moving = 1'b1;
               if (level[c] == `LEVEL_ZERO)
                  next_state = ST_OFF;
               else if (tick)
                  next_level = level[c] - `LEVEL_STEP;   // [R15]
            end
         endcase
         if (crit_s) begin
            next_state = ST_OFF;   // [R20]
            next_level = `LEVEL_ZERO;
         end
         if (next_state == ST_OFF)
            next_level = `LEVEL_ZERO;
      end

      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
         if (!rstn_i) begin
            state[c]    <= ST_OFF;   // [R25]
            level[c]    <= `LEVEL_ZERO;
            step_cnt[c] <= '0;
         end else begin
            state[c]    <= next_state;
            level[c]    <= next_level;
            step_cnt[c] <= (moving && !tick) ? step_cnt[c] + 8'h01 : 8'h00;
         end
      end

      // good flag: rises on the rising threshold, drops on fall or over-level
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
         if (!rstn_i)
            good[c] <= 1'b0;
         else if (!ch_live[c] || fall_s[c] || high_s[c])
            good[c] <= 1'b0;   // [R3]
         else if (rise_s[c])
            good[c] <= 1'b1;   // [R3]
      end
   end

   // -------------------------------------------------------------------------
   // events and interrupt
   // -------------------------------------------------------------------------
   logic [3:0] events;
   wire  [1:0] oc_set = rise_edge[3:2] & ~(ramp_busy & {2{overcurrent_during_ramp_mask_i}});   // [R17]
   wire  [3:0] ev_set = {rise_edge[0], rise_edge[1], oc_set};   // [R16] [R21]
   wire  [3:0] ev_clr = clr_pulse ? clr_hold : 4'h0;
   wire  [3:0] ev_msk = {thermal_critical_event_mask_i, thermal_warning_event_mask_i,
                         overcurrent_irq_mask_i};
   wire        irq_now = (|(events & ~ev_msk)) || (warn_s && !thermal_warning_level_mask_i);

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         events <= '0;
      else
         events <= (events & ~ev_clr) | ev_set;   // [R23]
   end

   // -------------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------------
   wire signed [15:0] trim_ext = {{12{oscillator_trim_i[3]}}, oscillator_trim_i};
   wire        [15:0] osc_khz  = 16'(`OSC_NOM_KHZ + trim_ext * `OSC_STEP_KHZ);   // [R9]
   wire        [15:0] sw_khz   = 16'(`SW_NOM_KHZ + trim_ext * `SW_STEP_KHZ);

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i) begin
         target_level_o            <= '0;
         channel_on_o              <= '0;
         ramp_active_o             <= '0;
         forced_pwm_o              <= '0;
         pfm_active_o              <= '0;
         pulldown_on_o             <= 2'h3;
         rail1_good_flag_o         <= 1'b0;
         rail2_good_flag_o         <= 1'b0;
         thermal_warning_status_o  <= 1'b0;
         thermal_critical_status_o <= 1'b0;
         event_flags_o             <= '0;
         irq_n_o                   <= 1'b1;
         osc_freq_khz_o            <= `OSC_NOM_KHZ;
         sw_freq_khz_o             <= `SW_NOM_KHZ;
      end else begin
         target_level_o            <= {level[1], level[0]};
         channel_on_o              <= ch_live;
         ramp_active_o             <= ramp_busy;
         forced_pwm_o              <= ramp_busy;   // [R6]
         pfm_active_o              <= pfm_now;
         pulldown_on_o             <= ~pulldown_disable_i;   // [R8]
         rail1_good_flag_o         <= good[0];   // [R4]
         rail2_good_flag_o         <= good[1];
         thermal_warning_status_o  <= warn_s;   // [R19]
         thermal_critical_status_o <= crit_s;   // [R19]
         event_flags_o             <= events;
         irq_n_o                   <= ~irq_now;   // [R23]
         osc_freq_khz_o            <= osc_khz;
         sw_freq_khz_o             <= sw_khz;
      end
   end

   for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
      wire route1 = (gpio_mode_i[g] == 2'h1);
      wire route2 = (gpio_mode_i[g] == 2'h2);
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
         if (!rstn_i) begin
            gpio_o[g]    <= 1'b0;
            gpio_oe_o[g] <= 1'b0;
         end else begin
            gpio_o[g]    <= (route1 && good[0]) || (route2 && good[1]);   // [R4]
            gpio_oe_o[g] <= route1 || route2;
         end
      end
   end

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   AST_CRIT_SHUTS_BOTH: assert property (crit_s |=> state[0] == ST_OFF && state[1] == ST_OFF) // [R20]
      else $error("critical thermal did not stop both channels");
   AST_CEILING: assert property (state[0] == ST_ON && !ramp_busy[0] |-> // [R13]
                                 level[0] <= output_level_ceiling_i[0])
      else $error("channel one target above ceiling");
   AST_ONE_STEP: assert property (state[0] == ST_ON && $past(state[0]) == ST_ON &&
                                  level[0] != $past(level[0]) |->
                                  (level[0] == $past(level[0]) + 8'h01) ||
                                  (level[0] == $past(level[0]) - 8'h01)) // [R24]
      else $error("ramp moved by more than one step");
   AST_PWM_IN_RAMP: assert property (ramp_busy[0] |=> forced_pwm_o[0] && !pfm_active_o[0]) // [R6]
      else $error("not in forced pulse-width during ramp");
   AST_EVENT_STICKY: assert property (events[`EV_OC1] && !ev_clr[`EV_OC1] |=> events[`EV_OC1]) // [R23]
      else $error("event bit dropped without clear");
   AST_OC_RECORDED: assert property (oc_set[0] |=> events[`EV_OC1] ##1 event_flags_o.oc1) // [R16]
      else $error("over-current not recorded");
   AST_OC_RAMP_MASK: assert property (rise_edge[2] && ramp_busy[0] && overcurrent_during_ramp_mask_i &&
                                      !events[`EV_OC1] |=> !events[`EV_OC1]) // [R17]
      else $error("masked ramp over-current was recorded");
   AST_IRQ_MASKED: assert property ((events & ~ev_msk) != 4'h0 |=> !irq_n_o) // [R23]
      else $error("unmasked event gave no interrupt");
   AST_GOOD_DROP: assert property (good[0] && (fall_s[0] || high_s[0]) |=> !good[0] ##1 !rail1_good_flag_o) // [R3]
      else $error("good flag held past threshold");
   AST_STEP_SPACING: assert property (state[0] == ST_ON && ch1_transition_slew_i == 3'h4 &&
                                      $changed(level[0]) |=> $stable(level[0])[*4]) // [R7]
      else $error("ramp stepped faster than the slew");

   COV_RAMP: cover property (!ramp_busy[0] ##1 ramp_busy[0] [*8] ##[1:200] !ramp_busy[0]);
   COV_START_ON: cover property (state[0] == ST_START ##[1:500] state[0] == ST_ON);
   COV_IRQ: cover property (irq_n_o ##1 !irq_n_o);
   COV_SHDN: cover property (state[1] == ST_SHDN ##[1:500] state[1] == ST_OFF);

endmodule

// File: host_link_model.sv
// link-side host model that issues preset writes and event clears
`timescale 1ns/100ps
module host_link_model
   import buck_ctrl_pkg::*;
(
   input  wire logic          host_clk_i,
   output      logic          host_wr_o,
   output      preset_write_t wr_data_o,
   output      logic          host_clr_o,
   output      event_flags_t  clr_bits_o
);
   initial
   begin
      {host_wr_o, host_clr_o, wr_data_o, clr_bits_o} = '0;
   end
   // one-cycle request, then 8 idle cycles so the toggle sync never merges two
   task automatic send(input logic clr, input logic [9:0] d);
      @(negedge host_clk_i);
      host_wr_o  = ~clr;
      host_clr_o = clr;
      wr_data_o  = d;
      clr_bits_o = d[3:0];
      @(negedge host_clk_i);
      {host_wr_o, host_clr_o} = 2'h0;
      // released data is inverted once so nothing can lean on a stale value
      wr_data_o  = ~d;
      clr_bits_o = ~d[3:0];
      repeat (8) @(negedge host_clk_i);
   endtask
endmodule

// File: dual_buck_voltage_control_tb_top.sv
// self-checking bench for the dual converter control block
`timescale 1ns/100ps
module dual_buck_voltage_control_tb_top
   import buck_ctrl_pkg::*;
;
   typedef struct {int k; logic [15:0] v;} note_t;
   logic ref_clk_i = 1'b0, host_clk_i = 1'b0, rstn_i, host_wr_i, host_clr_i, select_pin_i;
   logic temp_warn_i, thermal_critical_status_i, overcurrent_during_ramp_mask_i, irq_n_o;
   logic thermal_warning_event_mask_i, thermal_critical_event_mask_i;
   logic thermal_warning_level_mask_i, thermal_warning_status_o, thermal_critical_status_o;
   logic rail1_good_flag_o, rail2_good_flag_o;
   preset_write_t host_wr_data_i;
   event_flags_t host_clr_bits_i, event_flags_o;
   logic [1:0] ch_enable_i, preset_selector_i, sel_from_pin_i, pulldown_disable_i;
   logic [1:0] overcurrent_irq_mask_i, load_light_i, above_rise_i, below_fall_i, above_high_i;
   logic [1:0] current_limit_i, channel_on_o, ramp_active_o, forced_pwm_o, pfm_active_o;
   logic [1:0] pulldown_on_o;
   logic [2:0] ch1_transition_slew_i, ch2_transition_slew_i, gpio_o, gpio_oe_o;
   logic [1:0][7:0] output_level_ceiling_i, target_level_o;
   logic [1:0][2:0] startup_ramp_rate_i, shutdown_ramp_rate_i;
   logic [2:0][1:0] gpio_mode_i;
   conv_mode_t [1:0] ch1_conversion_mode_i, ch2_conversion_mode_i;
   logic [3:0] oscillator_trim_i;
   logic [7:0] status_link_o;
   logic [15:0] osc_freq_khz_o, sw_freq_khz_o;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   note_t notes[$];
   note_t cur;
   event fire;
   dual_buck_voltage_control dut (.*);
   host_link_model host (.host_clk_i(host_clk_i), .host_wr_o(host_wr_i),
      .wr_data_o(host_wr_data_i), .host_clr_o(host_clr_i), .clr_bits_o(host_clr_bits_i));
   always #50 ref_clk_i = ~ref_clk_i;
   always #32 host_clk_i = ~host_clk_i;
   function automatic logic [15:0] seen(input int k);
      case (k)
         0: return osc_freq_khz_o;
         1: return sw_freq_khz_o;
         2: return 16'(pulldown_on_o);
         3: return 16'(irq_n_o);
         4: return 16'(target_level_o[0]);
         5: return 16'(channel_on_o);
         6: return 16'(event_flags_o);
         7: return 16'({thermal_warning_status_o, thermal_critical_status_o});
         8: return 16'({pfm_active_o, forced_pwm_o});
         9: return 16'({gpio_oe_o, 1'b0, gpio_o});
         11: return 16'(target_level_o[1]);
         12: return 16'(status_link_o);
         default: return 16'({rail2_good_flag_o, rail1_good_flag_o});
      endcase
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      n_checks++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("ERROR %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic note(input int k, input logic [15:0] v);
      notes.push_back('{k, v});
      -> fire;
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(fire)
   begin
      cur = notes.pop_front();
      check(seen(cur.k), cur.v);
   end
   // run is about 800 cycles, so this only trips on a hang
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   initial
   begin
      void'($urandom(32'hD9D2));
      {rstn_i, select_pin_i, temp_warn_i, thermal_critical_status_i, overcurrent_during_ramp_mask_i} = '0;
      {thermal_warning_event_mask_i, thermal_critical_event_mask_i} = '0;
      {thermal_warning_level_mask_i, ch_enable_i, preset_selector_i, sel_from_pin_i} = '0;
      {pulldown_disable_i, overcurrent_irq_mask_i, load_light_i, above_rise_i} = '0;
      {below_fall_i, above_high_i, current_limit_i, shutdown_ramp_rate_i} = '0;
      {gpio_mode_i, oscillator_trim_i} = '0;
      ch1_conversion_mode_i[0] = MODE_AUTO;
      ch1_conversion_mode_i[1] = MODE_PFM;
      ch2_conversion_mode_i[0] = MODE_PWM;
      ch2_conversion_mode_i[1] = MODE_AUTO;
      output_level_ceiling_i = {8'hFF, 8'hFF};
      startup_ramp_rate_i = {3'h4, 3'h4};
      {ch1_transition_slew_i, ch2_transition_slew_i} = {3'h4, 3'h4};
      tick(4);
      rstn_i = 1'b1;
      note(0, 16'h1F40);
      note(2, 16'h0003);
      note(3, 16'h0001);
      oscillator_trim_i = 4'($urandom);
      pulldown_disable_i = 2'($urandom);
      load_light_i = 2'($urandom);
      gpio_mode_i = {2'h2, 2'h1, 2'h0};
      above_rise_i = 2'h3;
      tick(6);
      note(0, 16'(32'sh1F40 + 32'($signed(oscillator_trim_i)) * 32'shA0));
      note(1, 16'(32'shFA0 + 32'($signed(oscillator_trim_i)) * 32'sh50));
      note(2, {14'h0, ~pulldown_disable_i});
      host.send(1'b0, 10'h130);
      tick(1);
      ch_enable_i = 2'h3;
      tick(400);
      note(4, 16'h0046);
      note(10, 16'h0003);
      note(9, 16'h0066);
      note(8, 16'({1'b0, load_light_i[0], 2'h0}));
      shutdown_ramp_rate_i[1] = 3'h5;
      ch_enable_i = 2'h1;
      tick(20);
      note(11, 16'h0043);
      preset_selector_i = 2'h1;
      while (!ramp_active_o[0]) tick(1);
      note(8, 16'h0001);
      overcurrent_during_ramp_mask_i = 1'b1;
      current_limit_i = 2'h1;
      tick(3);
      current_limit_i = 2'h0;
      tick(3);
      note(6, 16'h0000);
      while (ramp_active_o[0]) tick(1);
      note(4, 16'h0030);
      note(8, 16'h0004);
      output_level_ceiling_i[0] = 8'h48;
      host.send(1'b0, 10'h160);
      tick(200);
      note(4, 16'h0048);
      overcurrent_irq_mask_i = 2'h1;
      current_limit_i = 2'h1; // brief over-current trip on channel one, its interrupt masked
      tick(3);
      current_limit_i = 2'h0;
      tick(6);
      note(6, 16'h0001);
      note(3, 16'h0001);
      overcurrent_irq_mask_i = 2'h0;
      tick(6);
      note(3, 16'h0000);
      host.send(1'b1, 10'h001);
      tick(8);
      note(6, 16'h0000);
      {thermal_warning_event_mask_i, thermal_warning_level_mask_i} = 2'h3;
      thermal_critical_event_mask_i = 1'b1;
      {temp_warn_i, thermal_critical_status_i} = 2'h3;
      tick(8);
      note(7, 16'h0003);
      note(5, 16'h0000);
      note(6, 16'h000C);
      note(3, 16'h0001);
      note(12, 16'h003C);
      thermal_warning_level_mask_i = 1'b0;
      tick(3);
      note(3, 16'h0000);
      rstn_i = 1'b0;
      tick(2);
      note(6, 16'h0000);
      note(2, 16'h0003);
      final_report();
   end
endmodule
